// ---- hdl/bal_params.svh ----
// Overview of operation
// - subtract file minus accum minus borrow, set flags
// - dest bit 0 to accum, 1 to file, for subtract, swap and xor file
// - nibble exchange swaps halves, no flags change
// - xor immediate into accum, zero flag only
// - direction load: 5 A, 6 B, 7 C
// - xor file register, routed by dest, zero only
`ifndef BAL_PARAMS_SVH
`define BAL_PARAMS_SVH
// ----------------------------------------------------------------
// operand selectors and reset values
// ----------------------------------------------------------------
`define BAL_DIR_SEL_A   7'h05
`define BAL_DIR_SEL_B   7'h06
`define BAL_DIR_SEL_C   7'h07
`define BAL_ACCUM_RST   8'h00
`define BAL_DIR_RST     8'hFF
`define BAL_DEST_ACCUM  1'h0
`define BAL_DEST_FILE   1'h1
`endif

// ---- hdl/bal_pkg.sv ----
// ----------------------------------------------------------------
// operation codes of the datapath
// ----------------------------------------------------------------
package bal_pkg;
  typedef enum logic [2:0]
  {
    BAL_OP_NONE = 3'h0,
    BAL_OP_SUBB = 3'h1,
    BAL_OP_SWAP = 3'h2,
    BAL_OP_XORI = 3'h3,
    BAL_OP_XORF = 3'h4,
    BAL_OP_DIR  = 3'h5
  } bal_op_type;
endpackage

// ---- hdl/bal_sub_core.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// combinational subtract with borrow and half borrow
// ----------------------------------------------------------------
module bal_sub_core
(
  input  wire logic [7:0] minuend_i,
  input  wire logic [7:0] subtrahend_i,
  input  wire logic       carry_i,
  output logic      [7:0] diff_o,
  output logic            carry_o,
  output logic            half_o
);
  logic [8:0] full_sum; // minuend + ~subtrahend + carry
  logic [4:0] low_sum;  // low nibble of same sum

  // two's complement: carry set means no borrow
  always_comb
  begin
    full_sum = {1'h0, minuend_i} + {1'h0, ~subtrahend_i} + {8'h00, carry_i};
    low_sum  = {1'h0, minuend_i[3:0]} + {1'h0, ~subtrahend_i[3:0]} + {4'h0, carry_i};
    diff_o   = full_sum[7:0];
    carry_o  = full_sum[8];
    half_o   = low_sum[4];
  end
endmodule
`default_nettype wire

// ---- hdl/bal_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "bal_params.svh"
// ----------------------------------------------------------------
// byte datapath for five instructions
// ----------------------------------------------------------------
module bal_top
(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             op_valid_i,  // one instruction per cycle
  input  wire bal_pkg::bal_op_type op_i,
  input  wire logic [6:0]       file_addr_i, // file address 0..127
  input  wire logic [7:0]       file_data_i, // addressed file value
  input  wire logic             dest_i,      // 0 accum, 1 file
  input  wire logic [7:0]       literal_i,   // immediate operand
  output logic      [7:0]       accum_o,
  output logic                  carry_o,
  output logic                  half_borrow_flag_o,
  output logic                  zero_o,
  output logic                  file_we_o,   // one-cycle write pulse
  output logic      [6:0]       file_waddr_o,
  output logic      [7:0]       file_wdata_o,
  output logic      [7:0]       port_a_direction_o,
  output logic      [7:0]       port_b_direction_o,
  output logic      [7:0]       port_c_direction_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] accum;
    logic       carry;
    logic       half;
    logic       zero;
    logic       we;
    logic [6:0] waddr;
    logic [7:0] wdata;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
  } bal_state_type;

  bal_state_type state;      // registered state
  bal_state_type next_state; // next value
  logic [1:0]    rst_sync;   // reset release chain
  logic          rst_b;      // synchronised reset
  logic [7:0]    sub_diff;   // subtract result
  logic          sub_carry;  // subtract carry out
  logic          sub_half;   // subtract half carry
  logic [7:0]    result;     // result of current op

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'h1};
  end
  assign rst_b = rst_sync[1];

  // subtractor instance
  bal_sub_core u_sub
  (
    .minuend_i    (file_data_i),
    .subtrahend_i (state.accum),
    .carry_i      (state.carry),
    .diff_o       (sub_diff),
    .carry_o      (sub_carry),
    .half_o       (sub_half)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state    = state;
    next_state.we = 1'h0;
    result        = 8'h00;
    if (op_valid_i)
    begin
      unique case (op_i)
        bal_pkg::BAL_OP_SUBB:
        begin
          result          = sub_diff;
          next_state.carry = sub_carry;
          next_state.half  = sub_half;
          next_state.zero  = (sub_diff == 8'h00);
        end
        bal_pkg::BAL_OP_SWAP:
          result = {file_data_i[3:0], file_data_i[7:4]};
        bal_pkg::BAL_OP_XORI:
        begin
          result          = state.accum ^ literal_i;
          next_state.zero = (result == 8'h00);
        end
        bal_pkg::BAL_OP_XORF:
        begin
          result          = state.accum ^ file_data_i;
          next_state.zero = (result == 8'h00);
        end
        bal_pkg::BAL_OP_DIR:
        begin
          // other selectors are ignored
          if (file_addr_i == `BAL_DIR_SEL_A)
            next_state.dir_a = state.accum;
          else if (file_addr_i == `BAL_DIR_SEL_B)
            next_state.dir_b = state.accum;
          else if (file_addr_i == `BAL_DIR_SEL_C)
            next_state.dir_c = state.accum;
        end
        default:
          result = 8'h00;
      endcase
      // route result
      if (op_i == bal_pkg::BAL_OP_XORI)
        next_state.accum = result;
      else if (op_i == bal_pkg::BAL_OP_SUBB || op_i == bal_pkg::BAL_OP_SWAP || op_i == bal_pkg::BAL_OP_XORF)
      begin
        if (dest_i == `BAL_DEST_ACCUM)
          next_state.accum = result;
        else
        begin
          next_state.we    = 1'h1;
          next_state.waddr = file_addr_i;
          next_state.wdata = result;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register, one cycle per instruction
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state       <= '0;
      state.accum <= `BAL_ACCUM_RST;
      state.dir_a <= `BAL_DIR_RST;
      state.dir_b <= `BAL_DIR_RST;
      state.dir_c <= `BAL_DIR_RST;
    end
    else
      state <= next_state;
  end

  // outputs straight from the state register
  assign accum_o            = state.accum;
  assign carry_o            = state.carry;
  assign half_borrow_flag_o = state.half;
  assign zero_o             = state.zero;
  assign file_we_o          = state.we;
  assign file_waddr_o       = state.waddr;
  assign file_wdata_o       = state.wdata;
  assign port_a_direction_o = state.dir_a;
  assign port_b_direction_o = state.dir_b;
  assign port_c_direction_o = state.dir_c;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_swap_flags: assert property (@(posedge clk_i) disable iff (!rst_b)
    op_valid_i && op_i == bal_pkg::BAL_OP_SWAP |=> $stable({carry_o, half_borrow_flag_o, zero_o}))
    else $error("swap changed flags");
  chk_xori_accum: assert property (@(posedge clk_i) disable iff (!rst_b)
    op_valid_i && op_i == bal_pkg::BAL_OP_XORI |=> accum_o == ($past(accum_o) ^ $past(literal_i))
      && zero_o == (accum_o == 8'h00) && $stable(carry_o))
    else $error("xor immediate wrong");
  chk_xorf_file: assert property (@(posedge clk_i) disable iff (!rst_b)
    op_valid_i && op_i == bal_pkg::BAL_OP_XORF && dest_i |=> file_we_o
      && file_wdata_o == ($past(accum_o) ^ $past(file_data_i)) && $stable(accum_o))
    else $error("xor file wrong");
  chk_dest_accum: assert property (@(posedge clk_i) disable iff (!rst_b)
    op_valid_i && op_i == bal_pkg::BAL_OP_SWAP && !dest_i |=> !file_we_o
      && accum_o == {$past(file_data_i[3:0]), $past(file_data_i[7:4])})
    else $error("swap to accum wrong");
  chk_subb_value: assert property (@(posedge clk_i) disable iff (!rst_b)
    op_valid_i && op_i == bal_pkg::BAL_OP_SUBB && !dest_i |=>
      accum_o == 8'($past(file_data_i) - $past(accum_o) - {7'h00, !$past(carry_o)}))
    else $error("subtract wrong");
  chk_dir_load: assert property (@(posedge clk_i) disable iff (!rst_b)
    op_valid_i && op_i == bal_pkg::BAL_OP_DIR && file_addr_i == `BAL_DIR_SEL_B |=>
      port_b_direction_o == $past(accum_o) && $stable(port_a_direction_o) && $stable(zero_o))
    else $error("direction load wrong");
  chk_idle_write: assert property (@(posedge clk_i) disable iff (!rst_b)
    !op_valid_i |=> !file_we_o && $stable(accum_o))
    else $error("idle cycle changed state");
  chk_write_pulse: assert property (@(posedge clk_i) disable iff (!rst_b)
    file_we_o |-> $past(op_valid_i) && $past(dest_i) && file_waddr_o == $past(file_addr_i))
    else $error("stray file write");

  // ----------------------------------------------------------------
  // instruction take steps shared by the checks below
  // ----------------------------------------------------------------
  // subtract taken at this edge
  sequence seq_take_subb;
    op_valid_i && op_i == bal_pkg::BAL_OP_SUBB;
  endsequence
  // file xor routed to the accumulator
  sequence seq_take_xorf_accum;
    op_valid_i && op_i == bal_pkg::BAL_OP_XORF && !dest_i;
  endsequence
  // direction load with a selector outside 5..7
  sequence seq_take_dir_refused;
    op_valid_i && op_i == bal_pkg::BAL_OP_DIR
      && (file_addr_i < `BAL_DIR_SEL_A || file_addr_i > `BAL_DIR_SEL_C);
  endsequence

  // flags from compares: carry and half set when no borrow occurs
  chk_subb_flags: assert property (@(posedge clk_i) disable iff (!rst_b)
    seq_take_subb |=>
      carry_o == ({1'h0, $past(file_data_i)} >= {1'h0, $past(accum_o)} + {8'h00, !$past(carry_o)})
      && half_borrow_flag_o == ({1'h0, $past(file_data_i[3:0])} >= {1'h0, $past(accum_o[3:0])} + {4'h0, !$past(carry_o)})
      && zero_o == ($past(file_data_i) == 8'($past(accum_o) + {7'h00, !$past(carry_o)})))
    else $error("subtract flags wrong");
  // file xor into the accumulator, zero only
  chk_xorf_accum: assert property (@(posedge clk_i) disable iff (!rst_b)
    seq_take_xorf_accum |=> accum_o == ($past(accum_o) ^ $past(file_data_i)) && !file_we_o
      && zero_o == (accum_o == 8'h00) && $stable(carry_o) && $stable(half_borrow_flag_o))
    else $error("xor file to accum wrong");
  // refused selector leaves every direction register alone
  chk_dir_refused: assert property (@(posedge clk_i) disable iff (!rst_b)
    seq_take_dir_refused |=> $stable(port_a_direction_o) && $stable(port_b_direction_o)
      && $stable(port_c_direction_o) && $stable(accum_o))
    else $error("refused direction load changed state");
  // selector 5 loads port a, port c and carry stay unchanged
  chk_dir_port_a: assert property (@(posedge clk_i) disable iff (!rst_b)
    op_valid_i && op_i == bal_pkg::BAL_OP_DIR && file_addr_i == `BAL_DIR_SEL_A |=>
      port_a_direction_o == $past(accum_o) && $stable(port_c_direction_o) && $stable(carry_o))
    else $error("port a direction load wrong");
  // immediate xor never writes the file
  chk_xori_dest: assert property (@(posedge clk_i) disable iff (!rst_b)
    op_valid_i && op_i == bal_pkg::BAL_OP_XORI |=> !file_we_o)
    else $error("xor immediate wrote file");
endmodule
`default_nettype wire

// ---- testbench/byte_alu_op_subset_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module byte_alu_op_subset_tb;
  // ----------------------------------------------------------------
  // stimulus, outputs and reference state
  // ----------------------------------------------------------------
  logic                clk_i = 1'h0;
  logic                rst_b_i = 1'h0;
  logic                op_valid_i = 1'h0;
  bal_pkg::bal_op_type op_i = bal_pkg::BAL_OP_NONE;
  logic [6:0]          file_addr_i = 7'h00;
  logic [7:0]          file_data_i = 8'h00;
  logic                dest_i = 1'h0;
  logic [7:0]          literal_i = 8'h00;
  wire  [7:0]          accum_o, file_wdata_o, pa, pb, pc;
  wire                 carry_o, half_borrow_flag_o, zero_o, file_we_o;
  wire  [6:0]          file_waddr_o;
  int                  failures = 0;
  int                  samples_checked = 0;
  logic [7:0]          w = 8'h00;  // expected accumulator
  logic                c = 1'h0, h = 1'h0, z = 1'h0;  // expected flags
  logic [7:0]          d[3] = '{8'hFF, 8'hFF, 8'hFF};  // expected directions
  bal_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .file_addr_i(file_addr_i), .file_data_i(file_data_i), .dest_i(dest_i), .literal_i(literal_i),
    .accum_o(accum_o), .carry_o(carry_o), .half_borrow_flag_o(half_borrow_flag_o), .zero_o(zero_o),
    .file_we_o(file_we_o), .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o),
    .port_a_direction_o(pa), .port_b_direction_o(pb), .port_c_direction_o(pc));
  // 100 ns clock
  always #50 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // accumulator, flags, directions against the reference
  task automatic state();
    chk(accum_o, w);
    chk({5'h00, carry_o, half_borrow_flag_o, zero_o}, {5'h00, c, h, z});
    chk(pa, d[0]);
    chk(pb, d[1]);
    chk(pc, d[2]);
  endtask
  // drive at a falling edge, return at the next one with results settled
  task automatic run(input bal_pkg::bal_op_type o, input logic [6:0] a, input logic [7:0] f,
                     input logic de, input logic [7:0] k);
    op_valid_i = 1'h1;
    op_i = o;
    file_addr_i = a;
    file_data_i = f;
    dest_i = de;
    literal_i = k;
    @(negedge clk_i);
  endtask
  // load the accumulator through the immediate xor
  task automatic setw(input logic [7:0] v);
    run(bal_pkg::BAL_OP_XORI, 7'h00, 8'h00, 1'h1, w ^ v);
    w = v;
    z = (v == 8'h00);
    state();
    chk({7'h00, file_we_o}, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_dir();
    for (int i = 4; i < 8; i++)
    begin
      setw(8'h11 * i[7:0]);
      run(bal_pkg::BAL_OP_DIR, i[6:0], 8'h00, 1'h0, 8'h00);
      if (i > 4)
        d[i - 5] = w;
      state();
    end
  endtask
  task automatic t_xorf();
    setw(8'hF0);
    run(bal_pkg::BAL_OP_XORF, 7'h03, 8'h0F, 1'h1, 8'h00);
    z = 1'h0;
    state();
    chk({file_we_o, file_waddr_o}, 8'h83);
    chk(file_wdata_o, 8'hFF);
    run(bal_pkg::BAL_OP_XORF, 7'h7F, 8'hF0, 1'h0, 8'h00);
    w = 8'h00;
    z = 1'h1;
    state();
    chk({7'h00, file_we_o}, 8'h00);
  endtask
  task automatic t_subb();
    logic [7:0] tw[5] = '{8'h01, 8'h0F, 8'h00, 8'h3C, 8'hFF};
    logic [7:0] tf[5] = '{8'h00, 8'h10, 8'h01, 8'h3C, 8'h80};
    logic [8:0] s;
    for (int i = 0; i < 5; i++)
    begin
      setw(tw[i]);
      run(bal_pkg::BAL_OP_SUBB, 7'h10, tf[i], i[0], 8'h00);
      s = {1'h0, tf[i]} + {1'h0, ~tw[i]} + {8'h00, c};
      h = ({1'h0, tf[i][3:0]} + {1'h0, ~tw[i][3:0]} + {4'h0, c}) > 5'h0F;
      c = s[8];
      z = (s[7:0] == 8'h00);
      if (!i[0])
        w = s[7:0];
      state();
      chk({7'h00, file_we_o}, {7'h00, i[0]});
      if (i[0])
        chk(file_wdata_o, s[7:0]);
    end
  endtask
  task automatic t_swap();
    run(bal_pkg::BAL_OP_SWAP, 7'h22, 8'hA5, 1'h0, 8'h00);
    w = 8'h5A;
    state();
    run(bal_pkg::BAL_OP_SWAP, 7'h22, 8'h3C, 1'h1, 8'h00);
    state();
    chk(file_wdata_o, 8'hC3);
    chk({7'h00, file_we_o}, 8'h01);
  endtask
  // idle cycle ends the write pulse, no-op changes nothing
  task automatic t_idle();
    op_valid_i = 1'h0;
    @(negedge clk_i);
    state();
    chk({7'h00, file_we_o}, 8'h00);
    chk(file_wdata_o, 8'hC3);
    run(bal_pkg::BAL_OP_NONE, 7'h05, 8'h99, 1'h1, 8'h12);
    state();
    chk({file_we_o, file_waddr_o}, 8'h22);
  endtask
  // reset in mid-run restores accumulator, flags and directions
  task automatic t_reset();
    op_valid_i = 1'h0;
    rst_b_i = 1'h0;
    @(negedge clk_i);
    w = 8'h00;
    c = 1'h0;
    h = 1'h0;
    z = 1'h0;
    d = '{8'hFF, 8'hFF, 8'hFF};
    state();
    chk(file_wdata_o, 8'h00);
    rst_b_i = 1'h1;
    repeat (3) @(negedge clk_i);
    state();
    setw(8'h3C);
  endtask
  // ----------------------------------------------------------------
  // verdict and run control
  // ----------------------------------------------------------------
  task automatic summarize();
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'h1;
    repeat (3) @(negedge clk_i);
    state();
    t_dir();
    t_xorf();
    t_subb();
    t_swap();
    t_idle();
    t_reset();
    op_valid_i = 1'h0;
    summarize();
  end
  // hang guard, far beyond the roughly 40 cycles the scenarios take
  initial
  begin
    #1000000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
